// ---- hpm_map.svh ----
`ifndef HPM_MAP_SVH
`define HPM_MAP_SVH
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define HPM_PORT_AND_STRING_CONFIG   8'h08
`define HPM_FIXED_DEVICE_PORT_MASK   8'h09
`define HPM_SELF_POWERED_OFF_MASK    8'h0a
`define HPM_BUS_POWERED_OFF_MASK     8'h0b
`define HPM_REMAP_PORT_MAP           8'h0c
`define HPM_REMAP_PORT_OFF           8'h0d
`define HPM_PORT_STATUS              8'h0e
// ----------------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------------
`define HPM_STRING_EN_BIT            0
`define HPM_PORT_NUMBERING_BIT       3
`define HPM_CONFIG_WRITE_MASK        8'h09
`define HPM_PORT_MASK                8'h0e
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define HPM_CONFIG_RESET             8'h00
`define HPM_FIXED_RESET              8'h00
`define HPM_SELF_OFF_RESET           8'h00
`define HPM_BUS_OFF_RESET            8'h00
`define HPM_REMAP_MAP_RESET          8'h00
`define HPM_REMAP_OFF_RESET          8'h00
`endif

// ---- hpm_pkg.sv ----
package hpm_pkg;
  // Numbering method selected by the config register
  typedef enum logic [1:0] {
    HPM_STANDARD = 2'b01,
    HPM_REMAP    = 2'b10
  } hpm_mode_type;
  // Logical port number, 0 means not presented
  typedef logic [1:0] hpm_port_num_type;
endpackage : hpm_pkg

// ---- hpm_config.sv ----
`timescale 1ns/100ps
`include "hpm_map.svh"
//
// Contract
// - Bit 3 of the port and string config register selects numbering and disabling.
// - In standard mode port n shows as n and higher ports shift down past disabled ones.
// - In re-map mode numbering and disabling come from the re-map registers only.
// - Bit 0 of the port and string config register enables string descriptors.
// - Bits 1 to 3 of the fixed device mask mark ports 1 to 3 non-removable.
// - Self-powered in standard mode, a 1 in the self-powered mask disables that port.
// - Any set of disabled ports is legal and the port count equals the enabled ports.
// - In standard mode remaining active ports are reordered so the hub still works toward the host.
// - Bus-powered in standard mode, the bus-powered mask disables ports likewise.
module hpm_config #(
  parameter int PORTS = 3
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              reset_n,
  // Register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [7:0]        reg_rdata,
  // Power source, high when self-powered
  input  wire logic              self_powered,
  // Hub configuration outputs
  output hpm_pkg::hpm_mode_type  numbering_mode,
  output logic                   string_enable,
  output logic      [PORTS:1]    port_enabled,
  output logic      [PORTS:1]    fixed_device_ports,
  output logic      [2:0]        port_count,
  output logic      [5:0]        logical_port_map
);
  import hpm_pkg::*;

  // --------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------
  logic [7:0] port_and_string_config;
  logic [7:0] fixed_device_port_mask;
  logic [7:0] self_powered_port_off_mask;
  logic [7:0] bus_powered_port_off_mask;
  logic [7:0] remap_port_map;
  logic [7:0] remap_port_off;

  // Count of set bits in a port vector
  function automatic logic [2:0] hpm_count(input logic [3:1] v);
    hpm_count = {2'b00, v[1]} + {2'b00, v[2]} + {2'b00, v[3]};
  endfunction : hpm_count

  // Register writes; reserved bits never stored
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      port_and_string_config     <= `HPM_CONFIG_RESET;
      fixed_device_port_mask     <= `HPM_FIXED_RESET;
      self_powered_port_off_mask <= `HPM_SELF_OFF_RESET;
      bus_powered_port_off_mask  <= `HPM_BUS_OFF_RESET;
      remap_port_map             <= `HPM_REMAP_MAP_RESET;
      remap_port_off             <= `HPM_REMAP_OFF_RESET;
    end else if (reg_write) begin
      case (reg_addr)
        `HPM_PORT_AND_STRING_CONFIG: port_and_string_config <=
          reg_wdata & `HPM_CONFIG_WRITE_MASK;
        `HPM_FIXED_DEVICE_PORT_MASK: fixed_device_port_mask <=
          reg_wdata & `HPM_PORT_MASK;
        `HPM_SELF_POWERED_OFF_MASK: self_powered_port_off_mask <=
          reg_wdata & `HPM_PORT_MASK;
        `HPM_BUS_POWERED_OFF_MASK: bus_powered_port_off_mask <=
          reg_wdata & `HPM_PORT_MASK;
        `HPM_REMAP_PORT_MAP: remap_port_map <= {2'b00, reg_wdata[5:0]};
        `HPM_REMAP_PORT_OFF: remap_port_off <= reg_wdata & `HPM_PORT_MASK;
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Port numbering
  // --------------------------------------------------------------------
  logic [3:1] next_enabled;
  logic [5:0] next_map;
  logic [2:0] next_count;
  logic       remap_sel;

  assign remap_sel = port_and_string_config[`HPM_PORT_NUMBERING_BIT];

  // Select disable source and map; build the contiguous map in standard mode only
  always_comb begin
    logic [1:0] slot;
    slot = 2'd0;
    next_map = 6'h00;
    if (remap_sel) begin
      next_enabled = ~remap_port_off[3:1];
      next_map = remap_port_map[5:0];
    end else begin
      if (self_powered)
        next_enabled = ~self_powered_port_off_mask[3:1];
      else
        next_enabled = ~bus_powered_port_off_mask[3:1];
      for (int i = 1; i <= 3; i++) begin
        if (next_enabled[i]) begin
          slot = slot + 2'd1;
          next_map[2*i-2 +: 2] = slot;
        end
      end
    end
    next_count = hpm_count(next_enabled);
  end

  // Registered configuration outputs
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      numbering_mode     <= HPM_STANDARD;
      string_enable      <= 1'b0;
      port_enabled       <= '0;
      fixed_device_ports <= '0;
      port_count         <= 3'd0;
      logical_port_map   <= 6'h00;
    end else begin
      numbering_mode     <= remap_sel ? HPM_REMAP : HPM_STANDARD;
      string_enable      <=
        port_and_string_config[`HPM_STRING_EN_BIT];
      port_enabled       <= next_enabled[PORTS:1];
      fixed_device_ports <= fixed_device_port_mask[PORTS:1];
      port_count         <= next_count;
      logical_port_map   <= next_map;
    end
  end

  // --------------------------------------------------------------------
  // Register read, data one cycle after strobe
  // --------------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `HPM_PORT_AND_STRING_CONFIG: reg_rdata <= port_and_string_config;
        `HPM_FIXED_DEVICE_PORT_MASK: reg_rdata <= fixed_device_port_mask;
        `HPM_SELF_POWERED_OFF_MASK:  reg_rdata <= self_powered_port_off_mask;
        `HPM_BUS_POWERED_OFF_MASK:   reg_rdata <= bus_powered_port_off_mask;
        `HPM_REMAP_PORT_MAP:         reg_rdata <= remap_port_map;
        `HPM_REMAP_PORT_OFF:         reg_rdata <= remap_port_off;
        `HPM_PORT_STATUS:            reg_rdata <= {1'b0, port_count,
                                                   port_enabled, 1'b0};
        default:                     reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  // Each check but a_reserved_zero starts on a sampled high reset_n, so the first edge
  // after release, where outputs still hold reset values, is skipped
  a_count_matches: assert property (
    @(posedge clock) disable iff (!reset_n)
    reset_n |=> port_count == hpm_count($past(next_enabled)))
    else $error("port count differs from enabled ports");
  a_self_disable: assert property (
    @(posedge clock) disable iff (!reset_n)
    reset_n && !remap_sel && self_powered |=>
    port_enabled == ~$past(self_powered_port_off_mask[3:1]))
    else $error("self-powered mask not applied");
  a_bus_disable: assert property (
    @(posedge clock) disable iff (!reset_n)
    reset_n && !remap_sel && !self_powered |=>
    port_enabled == ~$past(bus_powered_port_off_mask[3:1]))
    else $error("bus-powered mask not applied");
  a_remap_source: assert property (
    @(posedge clock) disable iff (!reset_n)
    reset_n && remap_sel |=> port_enabled == ~$past(remap_port_off[3:1]))
    else $error("re-map mode used wrong mask");
  a_remap_map: assert property (
    @(posedge clock) disable iff (!reset_n)
    reset_n && remap_sel |=> logical_port_map == $past(remap_port_map[5:0]))
    else $error("re-map mode used wrong port numbers");
  a_mode_bit: assert property (
    @(posedge clock) disable iff (!reset_n)
    reset_n |=> (numbering_mode == HPM_REMAP) == $past(remap_sel))
    else $error("numbering mode does not follow bit 3");
  a_string_bit: assert property (
    @(posedge clock) disable iff (!reset_n)
    reset_n && reg_write && reg_addr == `HPM_PORT_AND_STRING_CONFIG |->
    ##2 string_enable == $past(reg_wdata[0], 2))
    else $error("string enable does not follow bit 0");
  a_fixed_ports: assert property (
    @(posedge clock) disable iff (!reset_n)
    reset_n && reg_write && reg_addr == `HPM_FIXED_DEVICE_PORT_MASK |->
    ##2 fixed_device_ports == $past(reg_wdata[3:1], 2))
    else $error("fixed device ports wrong");
  a_first_slot: assert property (
    @(posedge clock) disable iff (!reset_n)
    reset_n && !remap_sel && next_enabled[1] |=>
    logical_port_map[1:0] == 2'd1)
    else $error("enabled port 1 not mapped to 1");
  a_off_unmapped: assert property (
    @(posedge clock) disable iff (!reset_n)
    reset_n && !remap_sel && !next_enabled[2] |=>
    logical_port_map[3:2] == 2'd0)
    else $error("disabled port 2 still numbered");
  a_last_slot: assert property (
    @(posedge clock) disable iff (!reset_n)
    reset_n && !remap_sel && next_enabled == 3'b111 |=>
    logical_port_map[5:4] == 2'd3)
    else $error("port 3 not numbered 3 with all ports on");
  a_reserved_zero: assert property (
    @(posedge clock) disable iff (!reset_n)
    (port_and_string_config[7:4] == 4'h0) &&
    (port_and_string_config[2:1] == 2'b00) &&
    (self_powered_port_off_mask[0] == 1'b0))
    else $error("reserved bit stored");
  a_reserved_read: assert property (
    @(posedge clock) disable iff (!reset_n)
    reset_n && reg_read && reg_addr == `HPM_PORT_AND_STRING_CONFIG |=>
    (reg_rdata & ~`HPM_CONFIG_WRITE_MASK) == 8'h00)
    else $error("reserved config bits read nonzero");
  // Main scenarios
  c_remap_mode: cover property (@(posedge clock) remap_sel);
  c_all_off: cover property (@(posedge clock) port_count == 3'd0);
  c_middle_off: cover property (@(posedge clock)
    !remap_sel && next_enabled == 3'b101);
  c_status_read: cover property (@(posedge clock)
    reg_read && reg_addr == `HPM_PORT_STATUS);
endmodule : hpm_config

// ---- hpm_host_model.sv ----
`timescale 1ns/100ps
// Host side: counts the ports that it can enumerate
module hpm_host_model (
  // Hub outputs seen by the host
  input  wire logic [5:0] logical_port_map,
  input  wire logic [3:1] fixed_device_ports,
  // What the host enumerates
  output logic      [2:0] host_ports,
  // Shown ports whose descriptors the hub must supply
  output logic      [2:0] hub_descr_ports
);
  // A port shows when its number is not zero; fixed devices
  // answer with their own descriptors, not the hub's
  always_comb begin
    host_ports = 3'h0;
    hub_descr_ports = 3'h0;
    for (int n = 0; n < 3; n++)
      if (logical_port_map[2*n +: 2] != 2'h0) begin
        host_ports = host_ports + 3'h1;
        if (!fixed_device_ports[n+1])
          hub_descr_ports = hub_descr_ports + 3'h1;
      end
  end
endmodule : hpm_host_model

// ---- tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  import hpm_pkg::*;
  logic         clock, reset_n, reg_write, reg_read, self_powered;
  logic [7:0]   reg_addr, reg_wdata, reg_rdata;
  hpm_mode_type numbering_mode;
  logic         string_enable;
  logic [3:1]   port_enabled, fixed_device_ports;
  logic [2:0]   port_count, host_ports, hub_descr_ports;
  logic [5:0]   logical_port_map;
  int           n_errors, checks, cyc;
  hpm_config uut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .self_powered(self_powered),
    .numbering_mode(numbering_mode), .string_enable(string_enable),
    .port_enabled(port_enabled), .fixed_device_ports(fixed_device_ports),
    .port_count(port_count), .logical_port_map(logical_port_map));
  hpm_host_model host (.logical_port_map(logical_port_map),
    .fixed_device_ports(fixed_device_ports), .host_ports(host_ports),
    .hub_descr_ports(hub_descr_ports));
  // Clock and a cycle ceiling against hangs
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a; reg_wdata <= d; reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a; reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, exp);
    @(posedge clock);
    #1 chk(reg_rdata, 8'h00);
  endtask : rd
  // Expected count and map for a set of disabled ports
  function automatic logic [8:0] exp_map(input logic [3:1] off);
    logic [5:0] m; logic [2:0] k;
    m = 6'h00; k = 3'h0;
    for (int n = 1; n <= 3; n++)
      if (!off[n]) begin k++; m[2*n-1 -: 2] = k[1:0]; end
    return {k, m};
  endfunction : exp_map
  task automatic t_reset();
    chk(port_count, 8'h03);
    chk(logical_port_map, 8'h39);
    chk(numbering_mode, HPM_STANDARD);
    rd(8'h09, 8'h00);
    rd(8'h0a, 8'h00);
  endtask : t_reset
  task automatic t_config();
    wr(8'h08, 8'hff);
    rd(8'h08, 8'h09);
    chk(string_enable, 1'b1);
    chk(numbering_mode, HPM_REMAP);
    wr(8'h08, 8'h00);
    chk(string_enable, 1'b0);
    chk(numbering_mode, HPM_STANDARD);
  endtask : t_config
  task automatic t_masks(input logic sp);
    logic [8:0] e;
    @(posedge clock);
    self_powered <= sp;
    wr(sp ? 8'h0b : 8'h0a, 8'h0e);
    for (int i = 0; i < 8; i++) begin
      e = exp_map(i[2:0]);
      wr(sp ? 8'h0a : 8'h0b, {4'hf, i[2:0], 1'b1});
      chk(port_enabled, {5'h00, ~i[2:0]});
      chk(port_count, e[8:6]);
      chk(logical_port_map, e[5:0]);
      chk(host_ports, e[8:6]);
      chk(hub_descr_ports, e[8:6]);
      rd(sp ? 8'h0a : 8'h0b, {4'h0, i[2:0], 1'b0});
    end
    wr(8'h0a, 8'h00);
    wr(8'h0b, 8'h00);
  endtask : t_masks
  task automatic t_fixed();
    wr(8'h09, 8'hff);
    chk(fixed_device_ports, 3'h7);
    chk(hub_descr_ports, 8'h00);
    rd(8'h09, 8'h0e);
    rd(8'h0e, 8'h3e);
    rd(8'h20, 8'h00);
  endtask : t_fixed
  task automatic t_remap();
    wr(8'h0a, 8'h0e);
    wr(8'h0d, 8'h04);
    wr(8'h0c, 8'h21);
    wr(8'h08, 8'h08);
    chk(port_enabled, 3'h5);
    chk(port_count, 8'h02);
    chk(logical_port_map, 8'h21);
  endtask : t_remap
  task automatic summarize();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  // Main sequence
  initial begin
    reset_n = 1'b0; reg_write = 1'b0; reg_read = 1'b0; self_powered = 1'b1;
    reg_addr = 8'h00; reg_wdata = 8'h00; n_errors = 0; checks = 0; cyc = 0;
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    #1 t_reset();
    t_config();
    t_masks(1'b1);
    t_masks(1'b0);
    t_fixed();
    t_remap();
    summarize();
  end
endmodule : tb_top
